// >>> hw/stcd_top.sv
// Purpose: enable/disable self-test decode with status responses
// Assumes: frame checksum checked upstream, flag crc_ok in the frame
// Notes: registers over AXI4-Lite, one write and one read at a time
`timescale 1ns/1ps
module stcd_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire stcd_pkg::stcd_frame_t FRAME,
  input wire logic RESERVOIR_LOW,
  input wire logic INT_FAULT,
  output stcd_pkg::stcd_resp_t RESP,
  output logic DIAG_DRIVE,
  output logic LOCKOUT,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [31:0] ctrl_q;
  logic [31:0] setup_q;
  logic diag_q;
  logic lock_q;
  logic last_off_q;
  logic [15:0] last_rsp_q;
  logic [7:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic lock_clr_pulse;
  logic [3:0] node_addr;
  logic [3:0] f_cmd;
  logic [3:0] f_addr;
  logic fmt_ok;
  logic frame_usable;
  logic hit_on;
  logic hit_off;
  logic [7:0] low_byte;
  logic [31:0] rd_word;
  logic rd_ok;

  // byte-lane merge used by both writable registers
  function automatic logic [31:0] stcd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign node_addr = ctrl_q[stcd_pkg::CTRL_ADDR_LSB +: 4];
  assign f_cmd = FRAME.bits[stcd_pkg::FR_CMD_LSB +: 4];
  assign f_addr = FRAME.bits[stcd_pkg::FR_ADDR_LSB +: 4];

  // format acceptance: enhanced formats only once configured
  always_comb begin
    unique case (FRAME.fmt)
      stcd_pkg::STCD_FMT_STD_LONG: fmt_ok = 1'b1;
      stcd_pkg::STCD_FMT_STD_SHORT: fmt_ok = 1'b1;
      stcd_pkg::STCD_FMT_ENH_LONG: fmt_ok = ctrl_q[stcd_pkg::CTRL_ENH_LONG];
      stcd_pkg::STCD_FMT_ENH_SHORT: fmt_ok = ctrl_q[stcd_pkg::CTRL_ENH_SHORT];
    endcase
  end

  // data byte is never looked at here; checksum verdict arrives ready made
  assign frame_usable = FRAME.valid && !FRAME.downstream
                        && FRAME.crc_ok && fmt_ok;
  // ids 1110 and 1111 match neither command and fall through silently
  assign hit_on = frame_usable && (f_cmd == stcd_pkg::CMD_DIAG_ON)
                  && (f_addr != stcd_pkg::ADDR_GLOBAL)
                  && (f_addr == node_addr);
  assign hit_off = frame_usable && (f_cmd == stcd_pkg::CMD_DIAG_OFF)
                   && ((f_addr == node_addr) || (f_addr == stcd_pkg::ADDR_GLOBAL));
  // software clear of the lockout, live in the cycle the write is applied
  assign lock_clr_pulse = wr_clear();

  // self-test drive: on with enable unless locked, off with disable
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      diag_q <= 1'b0;
    end else if (hit_off) begin
      diag_q <= 1'b0;
    end else if (lock_q) begin
      diag_q <= 1'b0;
    end else if (hit_on) begin
      diag_q <= 1'b1;
    end
  end

  // lockout: two disables in a row arm it; only an accepted enable breaks the run
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lock_q <= 1'b0;
      last_off_q <= 1'b0;
    end else begin
      if (RESERVOIR_LOW || lock_clr_pulse) begin
        lock_q <= 1'b0;
      end else if (hit_off && last_off_q) begin
        lock_q <= 1'b1;
      end
      if (hit_off) begin
        last_off_q <= 1'b1;
      end else if (hit_on) begin
        last_off_q <= 1'b0;
      end
    end
  end

  // response low byte, shared by both lengths
  always_comb begin
    low_byte = 8'h00;
    low_byte[stcd_pkg::RSP_OTP] = ctrl_q[stcd_pkg::CTRL_OTP];
    low_byte[stcd_pkg::RSP_RES_LOW] = RESERVOIR_LOW;
    low_byte[stcd_pkg::RSP_DIAG] = hit_on && !lock_q;
    low_byte[stcd_pkg::RSP_LINK] = ctrl_q[stcd_pkg::CTRL_LINK];
    low_byte[stcd_pkg::RSP_TAG_LSB +: 2] = setup_q[stcd_pkg::SETUP_TAG_LSB +: 2];
    low_byte[stcd_pkg::RSP_FAULT] = INT_FAULT;
  end

  // response register: only addressed enable/disable answers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RESP <= '0;
      last_rsp_q <= 16'h0000;
    end else begin
      RESP.valid <= (hit_on || hit_off) && (f_addr != stcd_pkg::ADDR_GLOBAL);
      RESP.long_fmt <= (FRAME.fmt == stcd_pkg::STCD_FMT_STD_LONG)
                       || (FRAME.fmt == stcd_pkg::STCD_FMT_ENH_LONG);
      if ((hit_on || hit_off) && (f_addr != stcd_pkg::ADDR_GLOBAL)) begin
        if ((FRAME.fmt == stcd_pkg::STCD_FMT_STD_LONG)
            || (FRAME.fmt == stcd_pkg::STCD_FMT_ENH_LONG)) begin
          RESP.bits <= {node_addr, 4'h0, low_byte};
          last_rsp_q <= {node_addr, 4'h0, low_byte};
        end else begin
          RESP.bits <= {8'h00, low_byte};
          last_rsp_q <= {8'h00, low_byte};
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DIAG_DRIVE <= 1'b0;
      LOCKOUT <= 1'b0;
    end else begin
      DIAG_DRIVE <= diag_q && !lock_q;
      LOCKOUT <= lock_q;
    end
  end

  // write decode of the lockout clear bit
  function automatic logic wr_clear();
    return aw_have_q && w_have_q && (aw_addr_q == stcd_pkg::REG_CTRL)
           && w_strb_q[1] && w_data_q[stcd_pkg::CTRL_LOCK_CLR];
  endfunction

  // axi write channel capture, either order
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_have_q && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (aw_have_q && w_have_q) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // register update and write response
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= stcd_pkg::CTRL_RESET;
      setup_q <= stcd_pkg::SETUP_RESET;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= stcd_pkg::AXI_OKAY;
    end else begin
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (aw_have_q && w_have_q) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= stcd_pkg::AXI_OKAY;
        unique case (aw_addr_q)
          stcd_pkg::REG_CTRL: begin
            ctrl_q <= stcd_merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_00FF;
          end
          stcd_pkg::REG_SETUP_ONE: begin
            setup_q <= stcd_merge(setup_q, w_data_q, w_strb_q) & 32'h0000_0003;
          end
          stcd_pkg::REG_STATUS, stcd_pkg::REG_LAST_RSP: begin
            S_AXI_BRESP <= stcd_pkg::AXI_OKAY;
          end
          default: begin
            S_AXI_BRESP <= stcd_pkg::AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // read mux
  always_comb begin
    rd_ok = 1'b1;
    unique case (S_AXI_ARADDR)
      stcd_pkg::REG_CTRL: rd_word = ctrl_q;
      stcd_pkg::REG_SETUP_ONE: rd_word = setup_q;
      stcd_pkg::REG_STATUS: rd_word = {28'h0000000, RESERVOIR_LOW, INT_FAULT, lock_q, diag_q && !lock_q};
      stcd_pkg::REG_LAST_RSP: rd_word = {16'h0000, last_rsp_q};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // axi read channel
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= stcd_pkg::AXI_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= rd_ok ? stcd_pkg::AXI_OKAY : stcd_pkg::AXI_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// >>> shared/stcd_pkg.sv
// Purpose: constants and carriers for the self-test command decoder
// Assumes: command frames arrive already deserialised with checksum verdict
// Notes: register offsets are byte addresses on a 32-bit AXI4-Lite bus
package stcd_pkg;
  // command identifiers
  localparam logic [3:0] CMD_DIAG_OFF = 4'hC;
  localparam logic [3:0] CMD_DIAG_ON = 4'hD;
  localparam logic [3:0] CMD_UNUSED = 4'hE;
  localparam logic [3:0] CMD_REV_INIT = 4'hF;
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam int CRC_WIDTH = 4;
  // frame field positions
  localparam int FR_CMD_LSB = 0;
  localparam int FR_ADDR_LSB = 4;
  localparam int FR_DATA_LSB = 8;
  // response field positions
  localparam int RSP_FAULT = 1;
  localparam int RSP_TAG_LSB = 2;
  localparam int RSP_LINK = 4;
  localparam int RSP_DIAG = 5;
  localparam int RSP_RES_LOW = 6;
  localparam int RSP_OTP = 7;
  localparam int RSP_ADDR_LSB = 12;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETUP_ONE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LAST_RSP = 8'h0C;
  // control fields and reset values
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_ENH_LONG = 4;
  localparam int CTRL_ENH_SHORT = 5;
  localparam int CTRL_LINK = 6;
  localparam int CTRL_OTP = 7;
  localparam int CTRL_LOCK_CLR = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int SETUP_TAG_LSB = 0;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STCD_FMT_STD_LONG = 2'h0,
    STCD_FMT_STD_SHORT = 2'h1,
    STCD_FMT_ENH_LONG = 2'h2,
    STCD_FMT_ENH_SHORT = 2'h3
  } stcd_fmt_t;

  // one received command frame
  typedef struct packed {
    logic valid;
    logic downstream;
    logic crc_ok;
    stcd_fmt_t fmt;
    logic [15:0] bits;
  } stcd_frame_t;

  // one response to send
  typedef struct packed {
    logic valid;
    logic long_fmt;
    logic [15:0] bits;
  } stcd_resp_t;
endpackage

// >>> tb/stcd_asserts.sv
// Purpose: port checks on frame decode and status responses
// Assumes: one frame per cycle, response one cycle after the frame
// Notes: sees only the top ports
`timescale 1ns/1ps
module stcd_asserts (
  input wire logic CLK,
  input wire logic NRST,
  input wire stcd_pkg::stcd_frame_t FRAME,
  input wire logic RESERVOIR_LOW,
  input wire logic INT_FAULT,
  input wire stcd_pkg::stcd_resp_t RESP,
  input wire logic DIAG_DRIVE,
  input wire logic LOCKOUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // good upstream frame, then the enable command on top of it
  sequence s_up; FRAME.valid && !FRAME.downstream && FRAME.crc_ok; endsequence
  sequence s_on; s_up ##0 FRAME.bits[3:0] == stcd_pkg::CMD_DIAG_ON; endsequence
  short_zero_a: assert property (RESP.valid && !RESP.long_fmt |-> RESP.bits[15:8] == 8'h00)
    else $error("short response upper bits not zero");
  long_zero_a: assert property (RESP.valid |-> RESP.bits[11:8] == 4'h0 && !RESP.bits[0])
    else $error("response zero field wrong");
  unused_cmd_a: assert property (FRAME.valid && FRAME.bits[3:0] == 4'hE |=> !RESP.valid)
    else $error("unused command answered");
  rev_init_a: assert property (FRAME.valid && FRAME.bits[3:0] == 4'hF |=> !RESP.valid)
    else $error("reverse init answered");
  downstream_a: assert property (FRAME.valid && FRAME.downstream |=> !RESP.valid)
    else $error("downstream frame answered");
  bad_crc_a: assert property (FRAME.valid && !FRAME.crc_ok |=> !RESP.valid)
    else $error("bad checksum frame answered");
  global_on_a: assert property (s_on ##0 FRAME.bits[7:4] == 4'h0 |=> !RESP.valid)
    else $error("global enable answered");
  lock_off_a: assert property (LOCKOUT |-> !DIAG_DRIVE)
    else $error("drive on under lockout");
  lock_flag_a: assert property (s_on ##0 LOCKOUT && !RESERVOIR_LOW |=> !RESP.bits[5])
    else $error("active flag set under lockout");
  on_drive_a: assert property (s_on ##1 RESP.valid && RESP.bits[5] |=> DIAG_DRIVE)
    else $error("drive not on after enable");
  status_flags_a: assert property (RESP.valid |->
    RESP.bits[6] == $past(RESERVOIR_LOW) && RESP.bits[1] == $past(INT_FAULT))
    else $error("reservoir or fault flag wrong");
endmodule
bind stcd_top stcd_asserts i_chk (.CLK(CLK), .NRST(NRST), .FRAME(FRAME),
  .RESERVOIR_LOW(RESERVOIR_LOW), .INT_FAULT(INT_FAULT), .RESP(RESP),
  .DIAG_DRIVE(DIAG_DRIVE), .LOCKOUT(LOCKOUT));

// >>> tb/stcd_dsi_master.sv
// Purpose: bus master model that issues command frames
// Assumes: checksum verdict is carried as a flag
// Notes: idle lines show inverted data, never the last value
`timescale 1ns/1ps
module stcd_dsi_master (
  input wire logic CLK,
  output stcd_pkg::stcd_frame_t FRAME
);
  initial FRAME = '0;
  // one single-cycle frame; payload is random since it only feeds the checksum
  task automatic send(input stcd_pkg::stcd_fmt_t f, input logic [3:0] c, input logic [3:0] a,
                      input logic ds, input logic crc);
    @(posedge CLK);
    FRAME <= {1'b1, ds, crc, f, 8'($urandom), a, c};
    @(posedge CLK);
    FRAME.valid <= 1'b0;
    FRAME.bits <= ~FRAME.bits;
  endtask
endmodule

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the self-test command decoder
// Assumes: node address and flags are set over the register bus
// Notes: responses are matched against a queue of expected words
`timescale 1ns/1ps
module tb_top;
  logic clk, nrst, res_low, int_fault, diag, lock;
  stcd_pkg::stcd_frame_t frame;
  stcd_pkg::stcd_resp_t resp;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [16:0] expq[$];
  logic [16:0] lastw;
  logic [3:0] node;
  int mismatches, tests_run, f;
  stcd_top i_dut (.CLK(clk), .NRST(nrst), .FRAME(frame), .RESERVOIR_LOW(res_low),
    .INT_FAULT(int_fault), .RESP(resp), .DIAG_DRIVE(diag), .LOCKOUT(lock),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  stcd_dsi_master i_mst (.CLK(clk), .FRAME(frame));
  // compare tasks
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rsp(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  // register bus write and read
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp_val(32'(bresp), 32'(r));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp_val(rdata, d);
    cmp_val(32'(rresp), 32'(r));
  endtask
  // expected response: otp and link set, tag 2'b10
  function automatic logic [16:0] rsp(input logic lng, st, rl, flt);
    logic [7:0] lo;
    lo = {1'b1, rl, st, 1'b1, 2'b10, flt, 1'b0};
    return lng ? {1'b1, node, 4'h0, lo} : {1'b0, 8'h00, lo};
  endfunction
  task automatic results;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // response watcher
  always @(negedge clk) begin
    if (resp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED at %0t: unexpected response", $time);
      end else cmp_rsp({resp.long_fmt, resp.bits}, expq.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
  initial begin
    nrst = 1'b0; res_low = 1'b0; int_fault = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    mismatches = 0; tests_run = 0;
    void'($urandom(32'hA091));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    node = 4'(1 + $urandom % 15);
    axr(stcd_pkg::REG_CTRL, 32'h0, stcd_pkg::AXI_OKAY);
    axr(stcd_pkg::REG_STATUS, 32'h0, stcd_pkg::AXI_OKAY);
    axr(8'h10, 32'h0, stcd_pkg::AXI_SLVERR);
    axw(8'h10, 32'h0, stcd_pkg::AXI_SLVERR);
    axw(stcd_pkg::REG_SETUP_ONE, 32'h2, stcd_pkg::AXI_OKAY);
    axw(stcd_pkg::REG_CTRL, {24'h0, 4'hC, node}, stcd_pkg::AXI_OKAY);
    i_mst.send(stcd_pkg::STCD_FMT_ENH_LONG, 4'hD, node, 1'b0, 1'b1);
    axw(stcd_pkg::REG_CTRL, {24'h0, 4'hF, node}, stcd_pkg::AXI_OKAY);
    for (f = 0; f < 4; f++) begin
      expq.push_back(rsp(!f[0], 1'b1, 1'b0, 1'b0));
      i_mst.send(stcd_pkg::stcd_fmt_t'(f), 4'hD, node, 1'b0, 1'b1);
    end
    @(negedge clk);
    cmp_val(32'(diag), 32'h1);
    axr(stcd_pkg::REG_STATUS, 32'h1, stcd_pkg::AXI_OKAY);
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hE, node, 1'b0, 1'b1);
    i_mst.send(stcd_pkg::STCD_FMT_STD_SHORT, 4'hF, node, 1'b0, 1'b1);
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hC, node, 1'b1, 1'b1);
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hC, node, 1'b0, 1'b0);
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hD, 4'h0, 1'b0, 1'b1);
    // foreign address, never the global one
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hC, (node == 4'hF) ? 4'hE : node + 4'h1,
               1'b0, 1'b1);
    @(negedge clk);
    cmp_val(32'(diag), 32'h1);
    repeat (2) begin
      expq.push_back(rsp(1'b0, 1'b0, 1'b0, 1'b0));
      i_mst.send(stcd_pkg::STCD_FMT_STD_SHORT, 4'hC, node, 1'b0, 1'b1);
    end
    // lockout output lags the frame edge by one more cycle
    repeat (2) @(negedge clk);
    cmp_val({30'h0, lock, diag}, 32'h2);
    @(posedge clk);
    int_fault <= 1'b1;
    expq.push_back(rsp(1'b1, 1'b0, 1'b0, 1'b1));
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hD, node, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    cmp_val(32'(diag), 32'h0);
    @(posedge clk);
    res_low <= 1'b1;
    repeat (3) @(negedge clk);
    cmp_val(32'(lock), 32'h0);
    expq.push_back(rsp(1'b0, 1'b0, 1'b1, 1'b1));
    i_mst.send(stcd_pkg::STCD_FMT_STD_SHORT, 4'hC, node, 1'b0, 1'b1);
    @(posedge clk);
    res_low <= 1'b0;
    int_fault <= 1'b0;
    expq.push_back(rsp(1'b1, 1'b1, 1'b0, 1'b0));
    i_mst.send(stcd_pkg::STCD_FMT_STD_LONG, 4'hD, node, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    cmp_val(32'(diag), 32'h1);
    cmp_val(32'(expq.size()), 32'h0);
    // last response register holds the final long answer
    lastw = rsp(1'b1, 1'b1, 1'b0, 1'b0);
    axr(stcd_pkg::REG_LAST_RSP, {16'h0000, lastw[15:0]}, stcd_pkg::AXI_OKAY);
    results();
  end
endmodule
